// >>> core/fsk_loop_modem.sv
/*
 * Half-duplex FSK modem core: phase-continuous sine modulator toward a DAC
 * and a filtering demodulator fed by ADC samples.
 * Assumes the host drives tx_req_n_in and tx_data_in asynchronously and the
 * ADC presents tone_in as offset-binary codes on the core clock.
 */
// How it works
// [RULE1] Symbol slot is 833 us, one bit each, 1.2 kbps both ways
// [RULE2] Modulator runs only while transmit request is low
// [RULE3] Tone is 1200 Hz or 2200 Hz chosen by transmit data level
// [RULE4] Tone switch keeps the phase accumulator running: no phase jump
// [RULE5] Host sends start, eight data, parity, stop characters
// [RULE6] Receive mode demodulates samples onto the receive data output
// [RULE7] Remote sends 11-bit characters so the demodulator works
// [RULE8] Recovered data leaves at nominal 1200 bit/s
// [RULE9] Receive reference and circuitry are off while modulating
// [RULE10] Receive state machine filters samples before demodulation
// [RULE11] One maps to mark 1.2 kHz, zero to space 2.2 kHz
// [RULE12] Request high selects demodulator in place of modulator
// [RULE13] Receive data idles high while modulating
module fsk_loop_modem
	import fsk_modem_pkg::*;
#(
	parameter int unsigned SAMPLE_WIDTH = fsk_modem_pkg::SAMPLE_W
) (
	input  wire logic                            ref_clk_in,
	input  wire logic                            rst_n_in,
	input  wire logic                            tx_req_n_in,
	input  wire logic                            tx_data_in,
	input  wire logic [SAMPLE_WIDTH-1:0]         tone_in,
	output logic      [SAMPLE_WIDTH-1:0]         tone_out,
	output logic                                 rx_data_out,
	output logic                                 rx_ref_en_out,
	output logic                                 tx_active_out
);
	import fsk_modem_pkg::*;

	// Pin synchronisers: three stages, change taken when last two agree.
	// A one-cycle glitch on a pin never reaches the adopted level.
	// Pin synchronisers: three stages, change taken when last two agree
	logic [2:0] req_sync_r, dat_sync_r;
	logic       req_n_r, dat_r;
	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			req_sync_r <= 3'h7;
			dat_sync_r <= 3'h7;
		end else begin
			req_sync_r <= {req_sync_r[1:0], tx_req_n_in};
			dat_sync_r <= {dat_sync_r[1:0], tx_data_in};
		end
	end
	wire req_agree = (req_sync_r[2:1] == SYNC_ONES) || (req_sync_r[2:1] == SYNC_ZEROS);
	wire dat_agree = (dat_sync_r[2:1] == SYNC_ONES) || (dat_sync_r[2:1] == SYNC_ZEROS);
	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			req_n_r <= 1'b1;
			dat_r   <= 1'b1;
		end else begin
			if (req_agree)
				req_n_r <= req_sync_r[2];
			if (dat_agree)
				dat_r <= dat_sync_r[2];
		end
	end

	mode_e mode;
	assign mode = req_n_r ? MODE_RX : MODE_TX; // [RULE12]
	wire tx_on = (mode == MODE_TX); // [RULE2]

	// Modulator: accumulator never reset on tone change
	logic [PHASE_W-1:0] phase_r, phase_nxt;
	wire  [PHASE_W-1:0] step = dat_r ? MARK_STEP : SPACE_STEP; // [RULE3] [RULE11]
	assign phase_nxt = tx_on ? phase_r + step : phase_r; // [RULE4]
	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in)
			phase_r <= '0;
		else
			phase_r <= phase_nxt;
	end

	// Quarter-wave table: 17 points from zero to crest, amplitude 2047 about mid code.
	// The other quarters mirror the index and the sign, so neighbouring
	// accumulator steps never differ by more than one table step.
	function automatic logic [11:0] quarter_sine(input logic [4:0] k);
		logic [11:0] v;
		v = 12'h000;
		unique case (k)
			5'h00: v = 12'h000;
			5'h01: v = 12'h0c9;
			5'h02: v = 12'h18f;
			5'h03: v = 12'h253;
			5'h04: v = 12'h310;
			5'h05: v = 12'h3c5;
			5'h06: v = 12'h472;
			5'h07: v = 12'h513;
			5'h08: v = 12'h5a8;
			5'h09: v = 12'h62f;
			5'h0a: v = 12'h6a7;
			5'h0b: v = 12'h70e;
			5'h0c: v = 12'h764;
			5'h0d: v = 12'h7a8;
			5'h0e: v = 12'h7d9;
			5'h0f: v = 12'h7f6;
			5'h10: v = 12'h7ff;
			default: v = 12'h7ff;
		endcase
		return v;
	endfunction
	function automatic logic [11:0] sine_lut(input logic [LUT_AW-1:0] idx);
		logic [4:0]  k;
		logic [11:0] v;
		k = idx[4] ? (5'h10 - {1'b0, idx[3:0]}) : {1'b0, idx[3:0]};
		v = quarter_sine(k);
		return idx[5] ? (12'h800 - v) : (12'h800 + v);
	endfunction

	wire [11:0] sine_now = sine_lut(phase_r[PHASE_W-1 -: LUT_AW]);
	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in)
			tone_out <= SAMPLE_WIDTH'(MID_CODE);
		else if (tx_on)
			tone_out <= SAMPLE_WIDTH'(sine_now);
		else
			tone_out <= SAMPLE_WIDTH'(MID_CODE);
	end
	assign tx_active_out = tx_on;

	// Receive side held off while modulating
	wire rx_on = (mode == MODE_RX); // [RULE9]
	assign rx_ref_en_out = rx_on; // [RULE9]

	// Receive sampler: sample, high-pass by mean removal, then
	// delay-and-multiply discriminator over a half mark period
	localparam int unsigned DLY = 4;
	logic [RX_DIV_W-1:0]       div_r;
	logic signed [SAMPLE_WIDTH:0] hp_r;
	logic signed [SAMPLE_WIDTH+7:0] mean_r;
	logic signed [SAMPLE_WIDTH:0] dly_r [DLY];
	logic signed [2*SAMPLE_WIDTH+5:0] lp_r;
	logic rx_bit_r;
	// Eight sample ticks span one 833 us symbol
	wire  tick = (div_r == RX_DIV_W'(RX_DIV - 1)); // [RULE1]
	wire signed [SAMPLE_WIDTH:0] s_in = $signed({1'b0, tone_in}) - $signed({1'b0, MID_CODE});
	wire signed [SAMPLE_WIDTH:0] s_hp = s_in - (SAMPLE_WIDTH+1)'(mean_r >>> 6);
	wire signed [2*SAMPLE_WIDTH+1:0] prod = s_hp * dly_r[DLY-1];
	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in || !rx_on) begin // [RULE9]
			div_r    <= '0;
			mean_r   <= '0;
			lp_r     <= '0;
			hp_r     <= '0;
			rx_bit_r <= 1'b1;
			for (int i = 0; i < DLY; i++)
				dly_r[i] <= '0;
		end else begin
			div_r <= tick ? '0 : div_r + 1'b1;
			if (tick) begin // [RULE10]
				mean_r <= mean_r + (SAMPLE_WIDTH+8)'(s_in) - (mean_r >>> 6);
				hp_r   <= s_hp;
				dly_r[0] <= s_hp;
				for (int i = 1; i < DLY; i++)
					dly_r[i] <= dly_r[i-1];
				lp_r <= lp_r + (2*SAMPLE_WIDTH+6)'(prod) - (lp_r >>> 2);
				// Mark gives negative correlation at this lag, space positive;
				// a quiet line reads as mark so the host sees no false start bit
				rx_bit_r <= !(lp_r > 0); // [RULE6] [RULE11] [RULE8]
			end
		end
	end
	assign rx_data_out = rx_on ? rx_bit_r : 1'b1; // [RULE13]

	// Assertions
	a_tone_idle_tx: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		!tx_on ##1 !tx_on |-> tone_out == SAMPLE_WIDTH'(MID_CODE)) // [RULE2]
		else $error("tone not idle outside modulator mode");
	a_phase_step_ok: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		tx_on |=> phase_r == $past(phase_r) + (($past(dat_r)) ? MARK_STEP : SPACE_STEP)) // [RULE3]
		else $error("phase step does not match data level");
	a_phase_cont_sw: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		$changed(dat_r) |-> phase_r == $past(phase_r) + $past(step) || !$past(tx_on)) // [RULE4]
		else $error("phase jumped on tone switch");
	a_rx_idle_high: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		tx_on |-> rx_data_out && !rx_ref_en_out) // [RULE13]
		else $error("receive data not idle while modulating");
	a_ref_off_tx: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		tx_on |=> div_r == '0 && lp_r == '0) // [RULE9]
		else $error("receive path active while modulating");
	a_mode_follow: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		$rose(req_sync_r[2]) && req_sync_r[1] |=> rx_ref_en_out) // [RULE12]
		else $error("mode did not follow request");
	a_sample_pace: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		tick && rx_on ##1 rx_on |-> div_r == '0) // [RULE10]
		else $error("sample divider wrong");
	a_bit_hold_tick: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		rx_on && !tick ##1 rx_on |-> $stable(rx_bit_r)) // [RULE8]
		else $error("receive bit changed between samples");

	// Two-cycle views of a steady mode, and a settled low data level
	sequence s_tx_steady;
		tx_on ##1 tx_on;
	endsequence
	sequence s_rx_steady;
		rx_on ##1 rx_on;
	endsequence
	sequence s_dat_settled_low;
		dat_sync_r[2:1] == SYNC_ZEROS;
	endsequence
	a_mode_exclusive: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		rx_ref_en_out != tx_active_out) // [RULE12]
		else $error("both or neither path enabled");
	a_tone_follows: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		s_tx_steady |-> tone_out == SAMPLE_WIDTH'($past(sine_now))) // [RULE2]
		else $error("tone does not follow the phase");
	a_phase_hold_rx: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		s_rx_steady |-> $stable(phase_r)) // [RULE2]
		else $error("phase moved while demodulating");
	a_data_sync_low: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		s_dat_settled_low |=> !dat_r) // [RULE3]
		else $error("settled space level not adopted");
	a_rx_mark_one: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		rx_on && tick && lp_r < 0 |=> rx_bit_r) // [RULE11]
		else $error("mark not read as one");
	a_rx_space_zero: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		rx_on && tick && lp_r > 0 |=> !rx_bit_r) // [RULE6]
		else $error("space not read as zero");
	a_sync_reject: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		req_sync_r[2] != req_sync_r[1] |=> $stable(req_n_r)) // [RULE12]
		else $error("mode taken before sync stages agree");
	a_rx_frozen_tx: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		s_tx_steady |-> rx_bit_r && div_r == '0) // [RULE9]
		else $error("receive state runs while modulating");
endmodule

// >>> shared/fsk_modem_pkg.sv
/*
 * Constants for the FSK loop modem: clock rate, tone and symbol timing,
 * phase accumulator and sample widths.
 * Assumes a single 100 MHz core clock; converters sit outside the block.
 */
package fsk_modem_pkg;
	localparam int unsigned CLK_HZ        = 100_000_000;
	localparam int unsigned SYMBOL_US     = 833;
	localparam int unsigned SYMBOL_CYCLES = (SYMBOL_US * (CLK_HZ / 1_000_000));
	localparam int unsigned MARK_HZ       = 1200;
	localparam int unsigned SPACE_HZ      = 2200;
	localparam int unsigned PHASE_W       = 32;
	localparam int unsigned SAMPLE_W      = 12;
	localparam int unsigned LUT_AW        = 6;
	// Phase step per clock: f * 2^32 / CLK_HZ
	localparam logic [PHASE_W-1:0] MARK_STEP  = PHASE_W'((64'(MARK_HZ) << 32) / 64'(CLK_HZ));
	localparam logic [PHASE_W-1:0] SPACE_STEP = PHASE_W'((64'(SPACE_HZ) << 32) / 64'(CLK_HZ));
	// Receive sample pace: 9600 samples/s, eight per symbol
	localparam int unsigned RX_SAMPLE_HZ  = 9600;
	localparam int unsigned RX_DIV        = CLK_HZ / RX_SAMPLE_HZ;
	localparam int unsigned RX_DIV_W      = 14;
	localparam logic [SAMPLE_W-1:0] MID_CODE = 12'h800;
	localparam logic [1:0] SYNC_ONES   = 2'h3;
	localparam logic [1:0] SYNC_ZEROS  = 2'h0;
	typedef enum logic [0:0] {MODE_TX, MODE_RX} mode_e;
endpackage

// >>> testbench/fsk_loop_modem_tb.sv
/* Self-checking bench for the FSK loop modem in transmit and receive mode.
 * Assumes the host model shortens bit time; tone_in rests at mid code. */
module fsk_loop_modem_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import fsk_modem_pkg::*;
	localparam int unsigned BIT = 4000;
	logic ref_clk_in = 0, rst_n_in = 0, rx_mode = 1, level = 1, go = 0;
	logic tx_req_n, tx_data, busy, rx_data_out, rx_ref_en_out, tx_active_out;
	logic [SAMPLE_W-1:0] tone_out, last_tone;
	int errors = 0, comparisons = 0, changes = 0, max_step = 0, d;
	always #5 ref_clk_in = ~ref_clk_in;
	host_uart_model #(.BIT_CYCLES(BIT)) host_uart_model_inst (.ref_clk_in(ref_clk_in),
		.rx_mode_in(rx_mode), .level_in(level), .go_in(go), .byte_in(8'h5a),
		.tx_req_n_out(tx_req_n), .tx_data_out(tx_data), .busy_out(busy));
	fsk_loop_modem fsk_loop_modem_inst (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
		.tx_req_n_in(tx_req_n), .tx_data_in(tx_data), .tone_in(MID_CODE),
		.tone_out(tone_out), .rx_data_out(rx_data_out),
		.rx_ref_en_out(rx_ref_en_out), .tx_active_out(tx_active_out));
	// Count output steps and the largest jump between neighbouring samples
	always @(posedge ref_clk_in) begin
		d = int'(tone_out) - int'(last_tone);
		if (tone_out !== last_tone) changes++;
		if (d < 0) d = -d;
		if (d > max_step) max_step = d;
		last_tone = tone_out;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		comparisons++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected at %0t: %s", $time, msg);
		end
	endtask
	task automatic test_done();
		$display("errors %0d comparisons %0d", errors, comparisons);
		if (errors == 0 && comparisons > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task automatic test_idle();
		repeat (8) @(posedge ref_clk_in);
		#1;
		check(tone_out, 12'h800, "tone while receiving");
		check(rx_ref_en_out, 1'b1, "reference off in receive");
		check(tx_active_out, 1'b0, "modulator on in receive");
		repeat (RX_DIV + 8) @(posedge ref_clk_in);
		#1;
		check(rx_data_out, 1'b1, "quiet line not read as mark");
	endtask
	task automatic test_tones();
		int e;
		@(posedge ref_clk_in) rx_mode <= 0;
		repeat (8) @(posedge ref_clk_in);
		#1;
		check(tx_active_out, 1'b1, "modulator not on");
		check(rx_ref_en_out, 1'b0, "reference on while sending");
		check(rx_data_out, 1'b1, "receive data not idle");
		for (int i = 0; i < 2; i++) begin
			@(posedge ref_clk_in) level <= (i == 0);
			repeat (8) @(posedge ref_clk_in);
			changes = 0;
			repeat (16384) @(posedge ref_clk_in);
			e = int'(64'(i == 0 ? MARK_HZ : SPACE_HZ) * 16384 * 64 / CLK_HZ);
			check(changes >= e - 2 && changes <= e + 2, 1'b1, "tone rate");
		end
	endtask
	task automatic test_frame();
		max_step = 0;
		@(posedge ref_clk_in) go <= 1;
		@(posedge ref_clk_in) go <= 0;
		repeat (11 * BIT + 20) @(posedge ref_clk_in);
		#1;
		check(busy, 1'b0, "character not finished");
		check(max_step < 256, 1'b1, "phase jump on tone switch");
		check(rx_data_out, 1'b1, "receive data moved while sending");
		@(posedge ref_clk_in) rx_mode <= 1;
		repeat (8) @(posedge ref_clk_in);
		#1;
		check(tone_out, 12'h800, "tone after return to receive");
		check(rx_ref_en_out, 1'b1, "reference not back");
	endtask
	initial begin
		#950_000;
		errors++;
		test_done();
	end
	initial begin
		repeat (2) @(posedge ref_clk_in);
		rst_n_in <= 1;
		test_idle();
		test_tones();
		test_frame();
		test_done();
	end
endmodule

// >>> testbench/host_uart_model.sv
/* Host side model: mode pin and serial characters toward the modem.
 * Assumes the bench sets BIT_CYCLES; the modem follows these bit edges. */
module host_uart_model
	import fsk_modem_pkg::*;
#(
	parameter int unsigned BIT_CYCLES = SYMBOL_CYCLES
) (
	input  wire logic       ref_clk_in,
	input  wire logic       rx_mode_in,
	input  wire logic       level_in,
	input  wire logic       go_in,
	input  wire logic [7:0] byte_in,
	output logic            tx_req_n_out,
	output logic            tx_data_out,
	output logic            busy_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [10:0]  frame_r = 11'h7ff;
	logic [3:0]   left_r  = 4'h0;
	int unsigned  cnt_r   = 0;
	assign tx_data_out = (left_r != 4'h0) ? frame_r[0] : level_in;
	assign busy_out    = (left_r != 4'h0);
	always_ff @(posedge ref_clk_in) begin
		tx_req_n_out <= rx_mode_in;
		if (go_in && left_r == 4'h0) begin
			frame_r <= {1'b1, ^byte_in, byte_in, 1'b0};
			left_r  <= 4'hb;
			cnt_r   <= 0;
		end else if (left_r != 4'h0) begin
			cnt_r <= (cnt_r == BIT_CYCLES - 1) ? 0 : cnt_r + 1;
			if (cnt_r == BIT_CYCLES - 1) begin
				frame_r <= {1'b1, frame_r[10:1]};
				left_r  <= left_r - 4'h1;
			end
		end
	end
endmodule
